/* verilog/etd_tx_dma.sv */
`timescale 1ns/1ns
`include "etd_defs.svh"
// Contract
// - Descriptor address takes upper 8 bits from upper base, rest from pointer.
// - Monitored-bad status is set when the source address misses the filter.
// - Go fetches config, sizes, count and fragment fields into internal registers.
// - Current pointer loads from link only after a good packet; not on halt.
// - Multi-fragment packets fetch next pointer and size after each fragment but the last.
// - Packet end writes status, reads link; list-last set flags done, clears go.
// - Collision restores pointer from saved copy and resends, at most fifteen times.
// - Bursts: six reads first, three per later fragment, write plus read at end.
// - Underrun, count error, a collision at count fifteen or enabled deferral abort, pointer kept.
// - Halt stops the engine once the status word of the packet is written.
// - Go written while running has no effect except in the cycle a packet end stops the engine, where go wins; the chain walk continues.
// - Go after a stop resumes where the engine stopped, not at list start.
// - Eleven registers are selected by a six-bit register index; the other indices read zero.
// - Link holds an even byte pointer (word index in bits 15:1); its lowest bit is the list-last flag.
// - Status word is eleven control status bits plus collision count on top.
module etd_tx_dma (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// AXI4-Lite register slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output wire logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output wire logic        wready,
	output wire logic [1:0]  bresp,
	output wire logic        bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output wire logic        arready,
	output wire logic [31:0] rdata,
	output wire logic [1:0]  rresp,
	output wire logic        rvalid,
	input  wire logic        rready,
	// Descriptor memory master
	output wire logic        busReq,
	input  wire logic        busGrant,
	output wire logic        memValid,
	output wire logic        memWrite,
	output wire logic [23:0] memAddr,
	output wire logic [15:0] memWdata,
	input  wire logic        memReady,
	input  wire logic [15:0] memRdata,
	// Transmit MAC side
	output wire logic        fragStart,
	output wire logic [23:0] fragAddr,
	output wire logic [15:0] fragSize,
	output wire logic        fragLast,
	input  wire logic        macFragDone,
	input  wire logic        macCollision,
	input  wire logic        macUnderrun,
	input  wire logic        macCountErr,
	input  wire logic        macDeferErr,
	input  wire logic        macSrcMiss
);
	etd_pkg::etd_ctl_t ctlReg, ctlNext;
	etd_pkg::etd_axi_t axiReg, axiNext;
	logic              wrFire;
	logic              swGo;
	logic              macErr;
	logic [15:0]       rdWord;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [2:0] etdLen(input etd_pkg::etd_burst_t b);
		case (b)
			etd_pkg::B_FIRST: etdLen = `ETD_LEN_FIRST;
			etd_pkg::B_FRAG:  etdLen = `ETD_LEN_FRAG;
			etd_pkg::B_END:   etdLen = `ETD_LEN_END;
			default:          etdLen = `ETD_LEN_LINK;
		endcase
	endfunction

	function automatic logic [15:0] etdMerge(input logic [15:0] o, input logic [31:0] d,
		input logic [3:0] s);
		etdMerge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	// Sets up access k of the current burst
	function automatic etd_pkg::etd_ctl_t etdIssue(input etd_pkg::etd_ctl_t x,
		input logic [2:0] k);
		logic [15:0]       ofs;
		logic [14:0]       wlo;
		etd_pkg::etd_ctl_t y;
		y = x;
		case (x.burst)
			etd_pkg::B_FIRST: ofs = `ETD_OFS_CONFIG + {13'h0000, k};
			etd_pkg::B_FRAG:  ofs = x.fragBase + {13'h0000, k};
			etd_pkg::B_END:   ofs = (k == 3'h0) ? `ETD_OFS_STATUS : x.fragBase;
			default:          ofs = x.linkOfs;
		endcase
		wlo = x.curPtr[15:1] + ofs[14:0];
		y.memValid = 1'b1;
		y.memWrite = (x.burst == etd_pkg::B_END) && (k == 3'h0);
		y.memAddr = {x.upperBase[7:0], wlo, 1'b0};
		y.memWdata = {x.collCount, x.sendCtl[10:0]};
		y.accIdx = k;
		return y;
	endfunction

	// New packet: remember pointer, clear status, fetch first burst
	function automatic etd_pkg::etd_ctl_t etdStart(input etd_pkg::etd_ctl_t x);
		etd_pkg::etd_ctl_t y;
		y = x;
		y.savedPtr = x.curPtr;
		y.sendCtl = x.sendCtl & ~`ETD_SC_STAT;
		y.collCount = 5'h00;
		y.abortFlag = 1'b0;
		y.fragBase = `ETD_OFS_FRAG0;
		y.burst = etd_pkg::B_FIRST;
		y.state = etd_pkg::S_ARB;
		y.busReq = 1'b1;
		return y;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register read mux
	always_comb begin
		rdWord = 16'h0000;
		case (araddr[7:2])
			`ETD_IDX_CMD:   rdWord = {14'h0000, ctlReg.goBit, ctlReg.haltBit};
			`ETD_IDX_SCTL:  rdWord = ctlReg.sendCtl;
			`ETD_IDX_INTST: rdWord = {14'h0000, ctlReg.intStatus};
			`ETD_IDX_UBASE: rdWord = ctlReg.upperBase;
			`ETD_IDX_CPTR:  rdWord = ctlReg.curPtr;
			`ETD_IDX_PSIZE: rdWord = ctlReg.pktSize;
			`ETD_IDX_FCNT:  rdWord = ctlReg.fragCount;
			`ETD_IDX_FLO:   rdWord = ctlReg.fragPtrLo;
			`ETD_IDX_FHI:   rdWord = ctlReg.fragPtrHi;
			`ETD_IDX_FSIZE: rdWord = ctlReg.fragLen;
			`ETD_IDX_SAVED: rdWord = ctlReg.savedPtr;
			default:        rdWord = 16'h0000; // Unused indices read zero
		endcase
	end

	// AXI channel handshakes; one write and one read in flight
	assign wrFire = axiReg.awHeld && axiReg.wHeld && !axiReg.bvalid;
	assign swGo = wrFire && (axiReg.awIdx == `ETD_IDX_CMD) && axiReg.wStrb[0] &&
		axiReg.wData[`ETD_CMD_GO];
	always_comb begin
		axiNext = axiReg;
		if (awvalid && axiReg.awready) begin
			axiNext.awHeld = 1'b1;
			axiNext.awIdx = awaddr[7:2];
		end
		if (wvalid && axiReg.wready) begin
			axiNext.wHeld = 1'b1;
			axiNext.wData = wdata;
			axiNext.wStrb = wstrb;
		end
		if (axiReg.bvalid && bready)
			axiNext.bvalid = 1'b0;
		if (wrFire) begin
			axiNext.awHeld = 1'b0;
			axiNext.wHeld = 1'b0;
			axiNext.bvalid = 1'b1;
		end
		if (arvalid && axiReg.arready) begin
			axiNext.rvalid = 1'b1;
			axiNext.rdata = {16'h0000, rdWord};
		end
		if (axiReg.rvalid && rready)
			axiNext.rvalid = 1'b0;
		axiNext.awready = !axiNext.awHeld;
		axiNext.wready = !axiNext.wHeld;
		axiNext.arready = !axiNext.rvalid;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Descriptor engine
	assign macErr = macUnderrun || macCountErr ||
		(macDeferErr && !ctlReg.sendCtl[`ETD_SC_XDEFDIS]);
	always_comb begin
		ctlNext = ctlReg;
		ctlNext.fragStart = 1'b0;
		// Software clears done/error first so a hardware set in this cycle wins
		if (wrFire && (axiReg.awIdx == `ETD_IDX_INTST) && axiReg.wStrb[0])
			ctlNext.intStatus = ctlReg.intStatus & ~axiReg.wData[1:0];
		case (ctlReg.state)
			etd_pkg::S_IDLE: begin
				if (ctlReg.goBit) begin
					if (ctlReg.resumeLink) begin
						ctlNext.burst = etd_pkg::B_LINK;
						ctlNext.state = etd_pkg::S_ARB;
						ctlNext.busReq = 1'b1;
					end else begin
						ctlNext = etdStart(ctlNext);
					end
				end
			end
			etd_pkg::S_ARB: begin
				// A grant counts only while our own request stands; a stale one is ignored
				ctlNext.busReq = 1'b1;
				if (ctlReg.busReq && busGrant) begin
					ctlNext = etdIssue(ctlNext, 3'h0);
					ctlNext.state = etd_pkg::S_ACC;
				end
			end
			etd_pkg::S_ACC: begin
				if (memReady) begin
					// Load fetched fields
					if (ctlReg.burst == etd_pkg::B_FIRST) begin
						case (ctlReg.accIdx)
							3'h0: ctlNext.sendCtl = (ctlReg.sendCtl & ~`ETD_SC_CFG) |
								(memRdata & `ETD_SC_CFG);
							3'h1: ctlNext.pktSize = memRdata;
							3'h2: begin
								ctlNext.fragCount = memRdata;
								ctlNext.fragsLeft = memRdata;
							end
							3'h3: ctlNext.fragPtrLo = memRdata;
							3'h4: ctlNext.fragPtrHi = memRdata;
							default: ctlNext.fragLen = memRdata;
						endcase
					end else if (ctlReg.burst == etd_pkg::B_FRAG) begin
						case (ctlReg.accIdx)
							3'h0: ctlNext.fragPtrLo = memRdata;
							3'h1: ctlNext.fragPtrHi = memRdata;
							default: ctlNext.fragLen = memRdata;
						endcase
					end
					if (ctlReg.accIdx == etdLen(ctlReg.burst) - 3'h1) begin
						// Burst done: release the bus before acting on it
						ctlNext.memValid = 1'b0;
						ctlNext.busReq = 1'b0;
						case (ctlReg.burst)
							etd_pkg::B_FIRST, etd_pkg::B_FRAG: begin
								ctlNext.fragBase = ctlReg.fragBase + `ETD_FRAG_WORDS;
								ctlNext.fragStart = 1'b1;
								ctlNext.fragAddr = {ctlNext.fragPtrHi[7:0], ctlNext.fragPtrLo};
								ctlNext.fragSize = ctlNext.fragLen;
								ctlNext.fragLast = ctlNext.fragsLeft <= 16'h0001;
								ctlNext.state = etd_pkg::S_SEND;
							end
							etd_pkg::B_END: begin
								ctlNext.state = etd_pkg::S_IDLE;
								ctlNext.goBit = 1'b0;
								ctlNext.resumeLink = 1'b0;
								if (ctlReg.abortFlag) begin
									ctlNext.intStatus[`ETD_INT_ERR] = 1'b1;
								end else if (ctlReg.haltBit) begin
									ctlNext.haltBit = 1'b0;
								end else if (memRdata[`ETD_LINK_LAST]) begin
									ctlNext.intStatus[`ETD_INT_DONE] = 1'b1;
									ctlNext.resumeLink = 1'b1;
									ctlNext.linkOfs = ctlReg.fragBase;
								end else begin
									ctlNext.goBit = 1'b1;
									ctlNext.curPtr = {memRdata[15:1], 1'b0};
									ctlNext = etdStart(ctlNext);
									ctlNext.busReq = 1'b0; // Release so the next burst arbitrates
								end
							end
							default: begin
								// Reread of the last link after a list-last stop
								if (memRdata[`ETD_LINK_LAST]) begin
									ctlNext.state = etd_pkg::S_IDLE;
									ctlNext.goBit = 1'b0;
									ctlNext.intStatus[`ETD_INT_DONE] = 1'b1;
								end else begin
									ctlNext.resumeLink = 1'b0;
									ctlNext.curPtr = {memRdata[15:1], 1'b0};
									ctlNext = etdStart(ctlNext);
									ctlNext.busReq = 1'b0; // Release so the next burst arbitrates
								end
							end
						endcase
					end else begin
						ctlNext = etdIssue(ctlNext, ctlReg.accIdx + 3'h1);
					end
				end
			end
			etd_pkg::S_SEND: begin
				if (macSrcMiss)
					ctlNext.sendCtl[`ETD_SC_MONBAD] = 1'b1;
				if (macErr || (macCollision && ctlReg.collCount == `ETD_RETRY_MAX)) begin
					// Abort still writes status, but leaves the pointer in place
					if (macUnderrun) ctlNext.sendCtl[`ETD_SC_UNDERRUN] = 1'b1;
					if (macCountErr) ctlNext.sendCtl[`ETD_SC_COUNTERR] = 1'b1;
					if (macDeferErr) ctlNext.sendCtl[`ETD_SC_XDEFER] = 1'b1;
					if (!macErr) begin
						ctlNext.sendCtl[`ETD_SC_XCOLL] = 1'b1;
						ctlNext.collCount = ctlReg.collCount + 5'h01;
					end
					ctlNext.abortFlag = 1'b1;
					ctlNext.burst = etd_pkg::B_END;
					ctlNext.state = etd_pkg::S_ARB;
					ctlNext.busReq = 1'b1;
				end else if (macCollision) begin
					ctlNext.collCount = ctlReg.collCount + 5'h01;
					ctlNext.curPtr = ctlReg.savedPtr;
					ctlNext.fragBase = `ETD_OFS_FRAG0;
					ctlNext.burst = etd_pkg::B_FIRST;
					ctlNext.state = etd_pkg::S_ARB;
					ctlNext.busReq = 1'b1;
				end else if (macFragDone) begin
					if (ctlReg.fragsLeft > 16'h0001) begin
						ctlNext.fragsLeft = ctlReg.fragsLeft - 16'h0001;
						ctlNext.burst = etd_pkg::B_FRAG;
					end else begin
						ctlNext.sendCtl[`ETD_SC_SENT] = 1'b1;
						ctlNext.burst = etd_pkg::B_END;
					end
					ctlNext.state = etd_pkg::S_ARB;
					ctlNext.busReq = 1'b1;
				end
			end
			default: ctlNext.state = etd_pkg::S_IDLE;
		endcase
		// Software writes last: a go set beats a stop in the same cycle
		if (wrFire) begin
			case (axiReg.awIdx)
				`ETD_IDX_CMD: begin
					if (swGo) ctlNext.goBit = 1'b1;
					if (axiReg.wStrb[0] && axiReg.wData[`ETD_CMD_HALT]) ctlNext.haltBit = 1'b1;
				end
				`ETD_IDX_SCTL: ctlNext.sendCtl = (ctlNext.sendCtl & ~`ETD_SC_CFG) |
					(etdMerge(ctlReg.sendCtl, axiReg.wData, axiReg.wStrb) & `ETD_SC_CFG);
				`ETD_IDX_UBASE: ctlNext.upperBase = etdMerge(ctlReg.upperBase, axiReg.wData,
					axiReg.wStrb);
				`ETD_IDX_CPTR: begin
					ctlNext.curPtr = etdMerge(ctlReg.curPtr, axiReg.wData, axiReg.wStrb);
					ctlNext.resumeLink = 1'b0;
				end
				default: ;
			endcase
		end
	end

	// State registers, synchronous reset
	always_ff @(posedge clock) begin
		if (rst) begin
			ctlReg <= '0;
			ctlReg.state <= etd_pkg::S_IDLE;
			ctlReg.burst <= etd_pkg::B_FIRST;
			axiReg <= '0;
		end else begin
			ctlReg <= ctlNext;
			axiReg <= axiNext;
		end
	end

	// Outputs straight from flops; responses are always OKAY
	assign awready = axiReg.awready;
	assign wready = axiReg.wready;
	assign bvalid = axiReg.bvalid;
	assign bresp = `ETD_RESP_OKAY;
	assign arready = axiReg.arready;
	assign rvalid = axiReg.rvalid;
	assign rdata = axiReg.rdata;
	assign rresp = `ETD_RESP_OKAY;
	assign busReq = ctlReg.busReq;
	assign memValid = ctlReg.memValid;
	assign memWrite = ctlReg.memWrite;
	assign memAddr = ctlReg.memAddr;
	assign memWdata = ctlReg.memWdata;
	assign fragStart = ctlReg.fragStart;
	assign fragAddr = ctlReg.fragAddr;
	assign fragSize = ctlReg.fragSize;
	assign fragLast = ctlReg.fragLast;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [2:0] hsCnt;
	always_ff @(posedge clock) begin
		if (rst || ctlReg.state == etd_pkg::S_ARB && !busGrant)
			hsCnt <= 3'h0;
		else if (ctlReg.memValid && memReady)
			hsCnt <= hsCnt + 3'h1;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_endLink;
		ctlReg.state == etd_pkg::S_ACC && ctlReg.burst == etd_pkg::B_END &&
			ctlReg.accIdx == 3'h1 && memReady && !wrFire;
	endsequence
	sequence s_sendQuiet;
		ctlReg.state == etd_pkg::S_SEND && !macErr && !wrFire;
	endsequence

	a_start_bus: assert property (ctlReg.state == etd_pkg::S_IDLE && ctlReg.goBit |=>
		busReq ##0 ctlReg.state == etd_pkg::S_ARB) else $error("go did not request bus");
	a_grant_access: assert property (ctlReg.state == etd_pkg::S_ARB && busReq && busGrant |=>
		memValid && busReq) else $error("grant did not start access");
	a_desc_upper: assert property (memValid |-> memAddr[23:16] == ctlReg.upperBase[7:0])
		else $error("descriptor upper address wrong");
	a_status_word: assert property (memValid && memWrite |->
		memWdata == {ctlReg.collCount, ctlReg.sendCtl[10:0]}) else $error("status word wrong");
	a_monbad_set: assert property (ctlReg.state == etd_pkg::S_SEND && macSrcMiss |=>
		ctlReg.sendCtl[`ETD_SC_MONBAD]) else $error("monitored bad not set");
	a_cfg_load: assert property (ctlReg.state == etd_pkg::S_ACC && memReady && !wrFire &&
		ctlReg.burst == etd_pkg::B_FIRST && ctlReg.accIdx == 3'h0 |=>
		ctlReg.sendCtl[15:12] == $past(memRdata[15:12])) else $error("config not loaded");
	a_frag_next: assert property (s_sendQuiet ##0 !macCollision && macFragDone &&
		ctlReg.fragsLeft > 16'h0001 |=> ctlReg.burst == etd_pkg::B_FRAG ##0 busReq)
		else $error("next fragment not fetched");
	a_burst_len: assert property ($fell(busReq) && $past(ctlReg.state) == etd_pkg::S_ACC |->
		hsCnt == etdLen($past(ctlReg.burst))) else $error("burst length wrong");
	a_eol_stop: assert property (s_endLink ##0 memRdata[0] && !ctlReg.abortFlag &&
		!ctlReg.haltBit |=> ctlReg.state == etd_pkg::S_IDLE && ctlReg.intStatus[`ETD_INT_DONE])
		else $error("list end did not stop with done");
	a_link_load: assert property (s_endLink ##0 !memRdata[0] && !ctlReg.abortFlag &&
		!ctlReg.haltBit |=> ctlReg.curPtr == {$past(memRdata[15:1]), 1'b0})
		else $error("link not loaded");
	a_halt_keep: assert property (s_endLink ##0 ctlReg.haltBit |=>
		$stable(ctlReg.curPtr) && ctlReg.state == etd_pkg::S_IDLE) else $error("halt failed");
	a_coll_retry: assert property (s_sendQuiet ##0 macCollision &&
		ctlReg.collCount < `ETD_RETRY_MAX |=> ctlReg.curPtr == ctlReg.savedPtr &&
		ctlReg.burst == etd_pkg::B_FIRST) else $error("collision retry wrong");
	a_abort_end: assert property (ctlReg.state == etd_pkg::S_SEND && macUnderrun |=>
		ctlReg.abortFlag && ctlReg.burst == etd_pkg::B_END) else $error("underrun no abort");
	a_resume_link: assert property (ctlReg.state == etd_pkg::S_IDLE && ctlReg.goBit &&
		ctlReg.resumeLink |=> ctlReg.burst == etd_pkg::B_LINK) else $error("no resume");
endmodule

/* verilog/etd_defs.svh */
`ifndef ETD_DEFS_SVH
`define ETD_DEFS_SVH
// Register word indices; the byte address is four times the index
`define ETD_IDX_CMD   6'h00
`define ETD_IDX_SCTL  6'h03
`define ETD_IDX_INTST 6'h05
`define ETD_IDX_UBASE 6'h06
`define ETD_IDX_CPTR  6'h07
`define ETD_IDX_PSIZE 6'h30
`define ETD_IDX_FCNT  6'h31
`define ETD_IDX_FLO   6'h32
`define ETD_IDX_FHI   6'h33
`define ETD_IDX_FSIZE 6'h34
`define ETD_IDX_SAVED 6'h35
// Command and interrupt status bit positions
`define ETD_CMD_HALT  0
`define ETD_CMD_GO    1
`define ETD_INT_DONE  0
`define ETD_INT_ERR   1
// Send control bit positions and masks
`define ETD_SC_SENT     0
`define ETD_SC_COUNTERR 1
`define ETD_SC_UNDERRUN 2
`define ETD_SC_MONBAD   3
`define ETD_SC_XCOLL    6
`define ETD_SC_XDEFER   10
`define ETD_SC_XDEFDIS  12
`define ETD_SC_CFG      16'hF000
`define ETD_SC_STAT     16'h07FF
`define ETD_LINK_LAST   0
// Descriptor word offsets
`define ETD_OFS_STATUS  16'h0000
`define ETD_OFS_CONFIG  16'h0001
`define ETD_OFS_FRAG0   16'h0004
`define ETD_FRAG_WORDS  16'h0003
// Burst lengths and retry limit
`define ETD_LEN_FIRST   3'h6
`define ETD_LEN_FRAG    3'h3
`define ETD_LEN_END     3'h2
`define ETD_LEN_LINK    3'h1
`define ETD_RETRY_MAX   5'h0F
`define ETD_RESP_OKAY   2'h0
`endif

/* verilog/etd_pkg.sv */
package etd_pkg;
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_ARB  = 4'b0010,
		S_ACC  = 4'b0100,
		S_SEND = 4'b1000
	} etd_state_t;
	typedef enum logic [3:0] {
		B_FIRST = 4'b0001,
		B_FRAG  = 4'b0010,
		B_END   = 4'b0100,
		B_LINK  = 4'b1000
	} etd_burst_t;
	typedef struct packed {
		etd_state_t  state;
		etd_burst_t  burst;
		logic [2:0]  accIdx;
		logic        goBit;
		logic        haltBit;
		logic        resumeLink;
		logic        abortFlag;
		logic [1:0]  intStatus;
		logic [15:0] sendCtl;
		logic [15:0] upperBase;
		logic [15:0] curPtr;
		logic [15:0] savedPtr;
		logic [15:0] pktSize;
		logic [15:0] fragCount;
		logic [15:0] fragPtrLo;
		logic [15:0] fragPtrHi;
		logic [15:0] fragLen;
		logic [15:0] fragsLeft;
		logic [15:0] fragBase;
		logic [15:0] linkOfs;
		logic [4:0]  collCount;
		logic        busReq;
		logic        memValid;
		logic        memWrite;
		logic [23:0] memAddr;
		logic [15:0] memWdata;
		logic        fragStart;
		logic        fragLast;
		logic [23:0] fragAddr;
		logic [15:0] fragSize;
	} etd_ctl_t;
	typedef struct packed {
		logic        awHeld;
		logic        wHeld;
		logic [5:0]  awIdx;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
	} etd_axi_t;
endpackage

/* bench/etd_mem_model.sv */
`timescale 1ns/1ns
// Descriptor memory with arbiter; slow mode answers every other cycle
module etd_mem_model #(
	parameter logic [7:0] HI = 8'h5A
) (
	// Clock and mode
	input  wire logic        clock,
	input  wire logic        slow,
	// Bus side
	input  wire logic        busReq,
	output logic             busGrant,
	input  wire logic        memValid,
	input  wire logic        memWrite,
	input  wire logic [23:0] memAddr,
	input  wire logic [15:0] memWdata,
	output logic             memReady,
	output logic [15:0]      memRdata,
	// Tallies
	output int               nRd,
	output int               nWr,
	output int               hiErr
);
	logic [15:0] mem [0:255];
	logic        tick = 1'b0;
	logic        go;
	initial begin
		busGrant = 1'b0;
		memReady = 1'b0;
		memRdata = 16'h0000;
		nRd = 0;
		nWr = 0;
		hiErr = 0;
	end
	assign go = memValid && !memReady && (!slow || tick);
	////////////////////////////////////////////////////////////////
	// Old data is inverted each cycle so a late sample never matches
	always @(posedge clock) begin
		tick <= ~tick;
		busGrant <= busReq;
		memReady <= go;
		memRdata <= ~memRdata;
		if (go && !memWrite)
			memRdata <= mem[memAddr[8:1]];
		if (memValid && memReady) begin
			if (memWrite)
				mem[memAddr[8:1]] <= memWdata;
			nWr <= nWr + (memWrite ? 1 : 0);
			nRd <= nRd + (memWrite ? 0 : 1);
			hiErr <= hiErr + ((memAddr[23:16] !== HI) ? 1 : 0);
		end
	end
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ns
`include "etd_defs.svh"
module tb_top;
	logic        clock = 1'b0, rst = 1'b1, slow = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        macFragDone = 0, macCollision = 0, macUnderrun = 0;
	logic        macCountErr = 0, macDeferErr = 0, macSrcMiss = 0;
	wire logic   awready, wready, bvalid, arready, rvalid, busReq, busGrant;
	wire logic   memValid, memWrite, memReady, fragStart, fragLast;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [23:0] memAddr, fragAddr;
	wire logic [15:0] memWdata, memRdata, fragSize;
	int          errTotal = 0, cmpCount = 0, cyc = 0, nRd, nWr, hiErr;
	logic [15:0] v;
	etd_tx_dma dut (.clock, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .busReq, .busGrant, .memValid, .memWrite, .memAddr, .memWdata,
		.memReady, .memRdata, .fragStart, .fragAddr, .fragSize, .fragLast, .macFragDone,
		.macCollision, .macUnderrun, .macCountErr, .macDeferErr, .macSrcMiss);
	etd_mem_model dm (.clock, .slow, .busReq, .busGrant, .memValid, .memWrite, .memAddr,
		.memWdata, .memReady, .memRdata, .nRd, .nWr, .hiErr);
	////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial forever #2 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errTotal++;
			tallyAndFinish();
		end
	end
	task tallyAndFinish();
		if (errTotal == 0 && cmpCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			errTotal++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Register bus; address and data may be taken in either order
	task wr(input logic [5:0] i, input logic [15:0] d);
		@(posedge clock);
		awaddr <= {i, 2'b00};
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		do @(posedge clock); while (bvalid !== 1'b1);
		chk(bresp, `ETD_RESP_OKAY);
		bready <= 1'b0;
	endtask
	task rd(input logic [5:0] i, output logic [15:0] d);
		@(posedge clock);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		d = rdata[15:0];
		chk(rresp, `ETD_RESP_OKAY);
		rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	// Host builds descriptors fully before any go
	function automatic logic [23:0] fa(input int b, input int f);
		return {8'h12, 16'(16'h1000 + f * 256 + b)};
	endfunction
	task desc(input int b, input int nf, input logic [15:0] link);
		dm.mem[b] = 16'h0000;
		dm.mem[b+1] = 16'h0000;
		dm.mem[b+2] = 16'(nf * 64);
		dm.mem[b+3] = 16'(nf);
		for (int f = 0; f < nf; f++) begin
			dm.mem[b+4+3*f] = 16'(fa(b, f));
			dm.mem[b+5+3*f] = 16'h0012;
			dm.mem[b+6+3*f] = 16'(64 + f);
		end
		dm.mem[b+4+3*nf] = link;
	endtask
	// k: 0 done, 1 collision, 2 underrun with count and deferral errors, 3 done with filter miss
	task frag(input int b, input int f, input logic l, input int k);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (fragStart !== 1'b1 && n < 600);
		chk(fragStart, 1'b1);
		chk(fragAddr, fa(b, f));
		chk(fragSize, 16'(64 + f));
		chk(fragLast, l);
		@(posedge clock);
		macFragDone <= (k == 0 || k == 3);
		macCollision <= (k == 1);
		macUnderrun <= (k == 2);
		macCountErr <= (k == 2);
		macDeferErr <= (k == 2);
		macSrcMiss <= (k == 3);
		@(posedge clock);
		{macFragDone, macCollision, macUnderrun, macSrcMiss} <= 4'h0;
		{macCountErr, macDeferErr} <= 2'b00;
	endtask
	task wait_int(input logic [15:0] e);
		int n;
		n = 0;
		do begin
			rd(`ETD_IDX_INTST, v);
			n++;
		end while (v === 16'h0000 && n < 300);
		chk(v, e);
		wr(`ETD_IDX_INTST, 16'h0003);
	endtask
	////////////////////////////////////////////////////////////////
	// Two-fragment packet chained to a one-fragment packet
	task sc_chain();
		desc(16, 2, 16'h0060);
		desc(48, 1, 16'h00A1);
		wr(`ETD_IDX_UBASE, 16'h005A);
		wr(6'h3E, 16'hFFFF);
		rd(`ETD_IDX_UBASE, v);
		chk(v, 16'h005A);
		wr(`ETD_IDX_CPTR, 16'h0020);
		wr(`ETD_IDX_CMD, 16'h0002);
		frag(16, 0, 1'b0, 0);
		wr(`ETD_IDX_CMD, 16'h0002);
		frag(16, 1, 1'b1, 0);
		frag(48, 0, 1'b1, 3);
		wait_int(16'h0001);
		rd(`ETD_IDX_CMD, v);
		chk(v[1], 1'b0);
		chk(dm.mem[16], 16'h0001);
		chk(dm.mem[48], 16'h0009);
		chk(nRd, 17);
		chk(nWr, 2);
		chk(hiErr, 0);
	endtask
	// Append behind the stopped list, slow memory, two collisions
	task sc_append();
		slow <= 1'b1;
		desc(80, 1, 16'h00E1);
		dm.mem[55] = 16'h00A0;
		wr(`ETD_IDX_CMD, 16'h0002);
		frag(80, 0, 1'b1, 1);
		frag(80, 0, 1'b1, 1);
		frag(80, 0, 1'b1, 0);
		wait_int(16'h0001);
		chk(dm.mem[80], 16'h1001);
		slow <= 1'b0;
	endtask
	// Underrun abort, resend, halt after status, then finish the list
	task sc_abort();
		int n;
		desc(112, 1, 16'h0120);
		desc(144, 1, 16'h0161);
		wr(`ETD_IDX_CPTR, 16'h00E0);
		wr(`ETD_IDX_CMD, 16'h0002);
		frag(112, 0, 1'b1, 2);
		wait_int(16'h0002);
		chk(dm.mem[112], 16'h0406);
		rd(`ETD_IDX_CPTR, v);
		chk(v, 16'h00E0);
		wr(`ETD_IDX_CMD, 16'h0002);
		wr(`ETD_IDX_CMD, 16'h0001);
		frag(112, 0, 1'b1, 0);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (dm.mem[112] !== 16'h0001 && n < 300);
		chk(dm.mem[112], 16'h0001);
		repeat (40) @(posedge clock);
		rd(`ETD_IDX_CPTR, v);
		chk(v, 16'h00E0);
		wr(`ETD_IDX_CMD, 16'h0002);
		frag(112, 0, 1'b1, 0);
		frag(144, 0, 1'b1, 0);
		wait_int(16'h0001);
		chk(hiErr, 0);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		sc_chain();
		sc_append();
		sc_abort();
		tallyAndFinish();
	end
endmodule
